//--- rtl/fxr_pkg.sv
// Constants shared by the exception, addressing and rounding logic of the float processor
// ****************************************************************
// ****************************************************************

package fxr_pkg;

   localparam logic [7:0] FXR_VECTOR = 8'hA4;

   localparam logic [3:0] FXR_CODE_NONE = 4'h0;
   localparam logic [3:0] FXR_CODE_OPCODE = 4'h2;
   localparam logic [3:0] FXR_CODE_DIVZERO = 4'h4;
   localparam logic [3:0] FXR_CODE_CONVERT = 4'h6;
   localparam logic [3:0] FXR_CODE_OVERFLOW = 4'h8;
   localparam logic [3:0] FXR_CODE_UNDERFLOW = 4'hA;
   localparam logic [3:0] FXR_CODE_UNDEFVAR = 4'hC;
   localparam logic [3:0] FXR_CODE_MAINT = 4'hE;

   localparam logic [15:0] FXR_ADDR_RESET = 16'h0000;

   localparam int FXR_BIT_ERROR = 15;
   localparam int FXR_BIT_DISABLE = 14;
   localparam int FXR_BIT_UNDEF_EN = 11;
   localparam int FXR_BIT_UNDER_EN = 10;
   localparam int FXR_BIT_OVER_EN = 9;
   localparam int FXR_BIT_CONV_EN = 8;
   localparam int FXR_BIT_DOUBLE = 7;
   localparam int FXR_BIT_CHOP = 5;
   localparam logic [15:0] FXR_STATUS_RESET = 16'h0000;

   localparam logic [2:0] FXR_MODE_ACC = 3'h0;
   localparam logic [2:0] FXR_MODE_DEFER = 3'h1;
   localparam logic [2:0] FXR_MODE_AINC = 3'h2;
   localparam logic [2:0] FXR_MODE_AINC_DEF = 3'h3;
   localparam logic [2:0] FXR_MODE_ADEC = 3'h4;
   localparam logic [2:0] FXR_MODE_ADEC_DEF = 3'h5;
   localparam logic [2:0] FXR_MODE_INDEX = 3'h6;
   localparam logic [2:0] FXR_MODE_INDEX_DEF = 3'h7;
   localparam logic [2:0] FXR_REG_PC = 3'h7;

   localparam logic [15:0] FXR_STEP_SINGLE = 16'h0004;
   localparam logic [15:0] FXR_STEP_DOUBLE = 16'h0008;
   localparam logic [15:0] FXR_STEP_WORD = 16'h0002;
   localparam logic [2:0] FXR_ACC_LAST_ALL = 3'h5;
   localparam logic [2:0] FXR_ACC_LAST_MEM = 3'h3;
   localparam logic [2:0] FXR_WORDS_IMM = 3'h1;
   localparam logic [2:0] FXR_WORDS_SINGLE = 3'h2;
   localparam logic [2:0] FXR_WORDS_DOUBLE = 3'h4;

   localparam int FXR_FRAC_W = 60;
   localparam int FXR_KEEP_SINGLE = 24;
   localparam int FXR_KEEP_DOUBLE = 56;
   localparam int FXR_EXP_W = 10;
   localparam logic [9:0] FXR_EXP_MAX = 10'h0FF;
   localparam logic [9:0] FXR_EXP_MIN = 10'h001;

endpackage

//--- rtl/fxr_round.sv
// Chop or round of a normalized 60-bit fraction to single or double width
`timescale 1ns/1ps

module fxr_round
   import fxr_pkg::*;
(
   input wire logic [FXR_FRAC_W-1:0] frac_in,
   input wire logic double_mode,
   input wire logic chop_mode,
   output logic [FXR_KEEP_DOUBLE-1:0] frac_out,
   output logic carry_out
);

   // ****************************************************************
   // Kept bits, rounding bit and guard bits
   // ****************************************************************
   // Bit 59 is headroom; the leading one sits at bit 58
   // Below the kept field lie 35 guard bits in single and 3 in double
   localparam int LSB_DBL = FXR_FRAC_W - 1 - FXR_KEEP_DOUBLE;
   localparam int LSB_SGL = FXR_FRAC_W - 1 - FXR_KEEP_SINGLE;
   localparam int PAD_SGL = FXR_KEEP_DOUBLE - FXR_KEEP_SINGLE;

   wire logic [FXR_KEEP_DOUBLE-1:0] kept_dbl = frac_in[FXR_FRAC_W-2:LSB_DBL];
   wire logic [FXR_KEEP_DOUBLE-1:0] kept_sgl = {frac_in[FXR_FRAC_W-2:LSB_SGL], {PAD_SGL{1'b0}}};
   wire logic round_bit = double_mode ? frac_in[LSB_DBL-1] : frac_in[LSB_SGL-1];
   wire logic bump = !chop_mode && round_bit;
   wire logic [FXR_KEEP_DOUBLE:0] lsb_one = double_mode ? {{FXR_KEEP_DOUBLE{1'b0}}, 1'b1} :
                                                          {{FXR_KEEP_SINGLE{1'b0}}, 1'b1, {PAD_SGL{1'b0}}};
   wire logic [FXR_KEEP_DOUBLE:0] kept = {1'b0, double_mode ? kept_dbl : kept_sgl};
   wire logic [FXR_KEEP_DOUBLE:0] summed = bump ? kept + lsb_one : kept;

   // A carry out leaves all other bits zero, so one right shift renormalizes
   assign carry_out = summed[FXR_KEEP_DOUBLE];
   assign frac_out = carry_out ? summed[FXR_KEEP_DOUBLE:1] : summed[FXR_KEEP_DOUBLE-1:0];

endmodule

//--- rtl/fxr_core.sv
// Float exception recording, operand addressing and result rounding
`timescale 1ns/1ps

module fxr_core
   import fxr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // Status load and store
   input wire logic status_load,
   input wire logic [15:0] status_load_data,
   input wire logic store_status_op,
   input wire logic maint_trap_enable,
   output logic [15:0] status_word,
   output logic store_valid,
   output logic [3:0] store_code,
   output logic [15:0] store_address,
   // Exceptions reported by the instruction sequencer
   input wire logic instr_done,
   input wire logic [15:0] instr_pc,
   input wire logic opcode_error,
   input wire logic conversion_error,
   input wire logic maint_trap,
   // Operand specifier
   input wire logic spec_valid,
   input wire logic [2:0] spec_mode,
   input wire logic [2:0] spec_reg,
   input wire logic [2:0] spec_acc,
   input wire logic [15:0] spec_reg_value,
   output logic addr_valid,
   output logic addr_use_acc,
   output logic [2:0] addr_acc_sel,
   output logic addr_acc_bad,
   output logic [15:0] addr_ea,
   output logic addr_deferred,
   output logic addr_indexed,
   output logic addr_reg_we,
   output logic [15:0] addr_reg_value,
   output logic [2:0] addr_words,
   // Operand zero check
   input wire logic opnd_valid,
   input wire logic opnd_from_mem,
   input wire logic opnd_is_divisor,
   input wire logic opnd_sign,
   input wire logic [7:0] opnd_exp,
   output logic opnd_exact_zero,
   output logic opnd_abort,
   // Result path
   input wire logic res_valid,
   input wire logic res_sign,
   input wire logic [FXR_EXP_W-1:0] res_exp,
   input wire logic [FXR_FRAC_W-1:0] res_frac,
   output logic out_valid,
   output logic out_sign,
   output logic [7:0] out_exp,
   output logic [FXR_KEEP_DOUBLE-1:0] out_frac,
   output logic overflow_flag,
   // Interrupt request
   output logic irq_req,
   output logic [7:0] irq_vector
);

   // ****************************************************************
   // Status bits
   // ****************************************************************
   logic [15:0] status_r;
   wire logic all_traps_disable = status_r[FXR_BIT_DISABLE];
   wire logic undefined_var_trap_enable = status_r[FXR_BIT_UNDEF_EN];
   wire logic underflow_trap_enable = status_r[FXR_BIT_UNDER_EN];
   wire logic overflow_trap_enable = status_r[FXR_BIT_OVER_EN];
   wire logic conversion_trap_enable = status_r[FXR_BIT_CONV_EN];
   wire logic double_mode = status_r[FXR_BIT_DOUBLE];
   wire logic chop_mode = status_r[FXR_BIT_CHOP];

   // ****************************************************************
   // Operand zero and undefined variable check
   // ****************************************************************
   wire logic opnd_exp_zero = opnd_valid && (opnd_exp == 8'h00);
   // Negative zero in an accumulator never traps, only one fetched from memory
   wire logic undef_hit = opnd_exp_zero && opnd_sign && opnd_from_mem && undefined_var_trap_enable;
   wire logic divzero_hit = opnd_exp_zero && opnd_is_divisor;

   // ****************************************************************
   // Result normalize, round, range check
   // ****************************************************************
   wire logic head_carry = res_frac[FXR_FRAC_W-1];
   wire logic [FXR_FRAC_W-1:0] frac_norm = head_carry ? {1'b0, res_frac[FXR_FRAC_W-1:1]} : res_frac;
   wire logic [FXR_KEEP_DOUBLE-1:0] rounded_frac;
   wire logic round_carry;

   fxr_round u_round
   (
      .frac_in(frac_norm),
      .double_mode(double_mode),
      .chop_mode(chop_mode),
      .frac_out(rounded_frac),
      .carry_out(round_carry)
   );

   wire logic [FXR_EXP_W-1:0] exp_adj = res_exp + {{(FXR_EXP_W-2){1'b0}}, 2'(head_carry) + 2'(round_carry)};
   wire logic exp_over = res_valid && !exp_adj[FXR_EXP_W-1] && (exp_adj > FXR_EXP_MAX);
   wire logic exp_under = res_valid && (exp_adj[FXR_EXP_W-1] || (exp_adj < FXR_EXP_MIN));
   wire logic over_trap = exp_over && overflow_trap_enable;
   wire logic under_trap = exp_under && underflow_trap_enable;
   // Untrapped range errors return exact zero rather than a wrapped exponent
   wire logic res_to_zero = (exp_over && !overflow_trap_enable) || (exp_under && !underflow_trap_enable);
   // Low byte of the exponent: 256 low on overflow, 256 high on nonzero underflow
   wire logic [7:0] exp_low = exp_adj[7:0];

   // ****************************************************************
   // Exception qualify and encode
   // ****************************************************************
   wire logic conv_trap = conversion_error && conversion_trap_enable;
   wire logic maint_qual = maint_trap && maint_trap_enable;
   wire logic record = instr_done && (opcode_error || divzero_hit || undef_hit || conv_trap
                        || over_trap || under_trap || maint_qual);

   // Only one code fits; the earliest-detected cause wins
   wire logic [3:0] code_nxt = opcode_error ? FXR_CODE_OPCODE :
                               undef_hit ? FXR_CODE_UNDEFVAR :
                               divzero_hit ? FXR_CODE_DIVZERO :
                               conv_trap ? FXR_CODE_CONVERT :
                               over_trap ? FXR_CODE_OVERFLOW :
                               under_trap ? FXR_CODE_UNDERFLOW :
                               FXR_CODE_MAINT;

   logic [3:0] code_r;
   logic [15:0] addr_r;
   logic irq_r;

   // Code and address have no write path except a recorded exception
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_r <= FXR_CODE_NONE;
         addr_r <= FXR_ADDR_RESET;
      end
      else if (record)
      begin
         code_r <= code_nxt;
         addr_r <= instr_pc;
      end
   end

   // Same edge as the code and address write
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_r <= 1'b0;
      else
         irq_r <= record && !all_traps_disable;
   end

   assign irq_req = irq_r;
   assign irq_vector = FXR_VECTOR;

   // Sticky error bit: a set in the loading cycle wins over the load
   wire logic [15:0] status_nxt = status_load ? status_load_data : status_r;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         status_r <= FXR_STATUS_RESET;
      else
      begin
         status_r <= status_nxt;
         if (record)
            status_r[FXR_BIT_ERROR] <= 1'b1;
      end
   end

   assign status_word = {status_r[15:14], 2'b00, status_r[11:0]};

   // ****************************************************************
   // Store status read port
   // ****************************************************************
   logic store_valid_r;
   logic [3:0] store_code_r;
   logic [15:0] store_addr_r;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         store_valid_r <= 1'b0;
         store_code_r <= FXR_CODE_NONE;
         store_addr_r <= FXR_ADDR_RESET;
      end
      else
      begin
         store_valid_r <= store_status_op;
         if (store_status_op)
         begin
            store_code_r <= code_r;
            store_addr_r <= addr_r;
         end
      end
   end

   assign store_valid = store_valid_r;
   assign store_code = store_code_r;
   assign store_address = store_addr_r;

   // ****************************************************************
   // Operand addressing
   // ****************************************************************
   wire logic is_acc = (spec_mode == FXR_MODE_ACC);
   wire logic is_imm = (spec_mode == FXR_MODE_AINC) && (spec_reg == FXR_REG_PC);
   wire logic is_defer = (spec_mode == FXR_MODE_AINC_DEF) || (spec_mode == FXR_MODE_ADEC_DEF);
   // Autoincrement and autodecrement deferred modes step over a one-word pointer; immediate steps over one word
   wire logic [15:0] step = (is_defer || is_imm) ? FXR_STEP_WORD :
                            (double_mode ? FXR_STEP_DOUBLE : FXR_STEP_SINGLE);
   wire logic is_inc = (spec_mode == FXR_MODE_AINC) || (spec_mode == FXR_MODE_AINC_DEF);
   wire logic is_dec = (spec_mode == FXR_MODE_ADEC) || (spec_mode == FXR_MODE_ADEC_DEF);
   wire logic [15:0] reg_dec = spec_reg_value - step;
   wire logic [15:0] reg_inc = spec_reg_value + step;
   wire logic [2:0] acc_last = is_acc ? FXR_ACC_LAST_ALL : FXR_ACC_LAST_MEM;
   wire logic [2:0] words = is_imm ? FXR_WORDS_IMM :
                            (double_mode ? FXR_WORDS_DOUBLE : FXR_WORDS_SINGLE);

   logic av_r;
   logic acc_r;
   logic [2:0] acc_sel_r;
   logic acc_bad_r;
   logic [15:0] ea_r;
   logic def_r;
   logic idx_r;
   logic rwe_r;
   logic [15:0] rval_r;
   logic [2:0] words_r;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         av_r <= 1'b0;
         acc_r <= 1'b0;
         acc_sel_r <= 3'h0;
         acc_bad_r <= 1'b0;
         ea_r <= 16'h0000;
         def_r <= 1'b0;
         idx_r <= 1'b0;
         rwe_r <= 1'b0;
         rval_r <= 16'h0000;
         words_r <= 3'h0;
      end
      else
      begin
         av_r <= spec_valid;
         if (spec_valid)
         begin
            acc_r <= is_acc;
            acc_sel_r <= spec_acc;
            acc_bad_r <= spec_acc > acc_last;
            ea_r <= is_dec ? reg_dec : spec_reg_value;
            def_r <= is_defer || (spec_mode == FXR_MODE_DEFER) || (spec_mode == FXR_MODE_INDEX_DEF);
            idx_r <= (spec_mode == FXR_MODE_INDEX) || (spec_mode == FXR_MODE_INDEX_DEF);
            rwe_r <= is_inc || is_dec;
            rval_r <= is_dec ? reg_dec : reg_inc;
            words_r <= is_acc ? 3'h0 : words;
         end
         else
            rwe_r <= 1'b0;
      end
   end

   assign addr_valid = av_r;
   assign addr_use_acc = acc_r;
   assign addr_acc_sel = acc_sel_r;
   assign addr_acc_bad = acc_bad_r;
   assign addr_ea = ea_r;
   assign addr_deferred = def_r;
   assign addr_indexed = idx_r;
   assign addr_reg_we = rwe_r;
   assign addr_reg_value = rval_r;
   assign addr_words = words_r;

   // ****************************************************************
   // Operand and result registers
   // ****************************************************************
   logic oz_r;
   logic oab_r;
   logic ov_r;
   logic os_r;
   logic [7:0] oe_r;
   logic [FXR_KEEP_DOUBLE-1:0] of_r;
   logic ovf_r;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         oz_r <= 1'b0;
         oab_r <= 1'b0;
         ov_r <= 1'b0;
         os_r <= 1'b0;
         oe_r <= 8'h00;
         of_r <= '0;
         ovf_r <= 1'b0;
      end
      else
      begin
         // Exact zero unless it is a trapped negative zero
         oz_r <= opnd_exp_zero && !undef_hit;
         oab_r <= divzero_hit || undef_hit;
         ov_r <= res_valid;
         if (res_valid)
         begin
            os_r <= res_to_zero ? 1'b0 : res_sign;
            oe_r <= res_to_zero ? 8'h00 : exp_low;
            of_r <= res_to_zero ? '0 : rounded_frac;
            ovf_r <= exp_over;
         end
      end
   end

   assign opnd_exact_zero = oz_r;
   assign opnd_abort = oab_r;
   assign out_valid = ov_r;
   assign out_sign = os_r;
   assign out_exp = oe_r;
   assign out_frac = of_r;
   assign overflow_flag = ovf_r;

endmodule

//--- sim/fxr_host_regs.sv
// Host general register file that feeds operand specifiers
`timescale 1ns/1ps

module fxr_host_regs
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic spec_valid,
   input wire logic [2:0] spec_reg,
   input wire logic addr_reg_we,
   input wire logic [15:0] addr_reg_value,
   output logic [15:0] spec_reg_value
);
   logic [15:0] gr_r [8];
   logic [2:0] sel_r;

   assign spec_reg_value = gr_r[spec_reg];

   // Writeback lands one cycle after the specifier, so the index is latched
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < 8; i++)
            gr_r[i] <= 16'h1000 + 16'(i * 256);
         sel_r <= 3'h0;
      end
      else
      begin
         if (spec_valid)
            sel_r <= spec_reg;
         if (addr_reg_we)
            gr_r[sel_r] <= addr_reg_value;
      end
   end
endmodule

//--- sim/fxr_core_props.sv
// Concurrent checks on the exception, addressing and result ports
`timescale 1ns/1ps

module fxr_core_props
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic status_load,
   input wire logic [15:0] status_word,
   input wire logic store_status_op,
   input wire logic store_valid,
   input wire logic instr_done,
   input wire logic opcode_error,
   input wire logic spec_valid,
   input wire logic [2:0] spec_mode,
   input wire logic [2:0] spec_reg,
   input wire logic [2:0] spec_acc,
   input wire logic [15:0] spec_reg_value,
   input wire logic addr_acc_bad,
   input wire logic addr_reg_we,
   input wire logic [15:0] addr_reg_value,
   input wire logic [2:0] addr_words,
   input wire logic opnd_valid,
   input wire logic opnd_sign,
   input wire logic [7:0] opnd_exp,
   input wire logic opnd_exact_zero,
   input wire logic res_valid,
   input wire logic [9:0] res_exp,
   input wire logic [7:0] out_exp,
   input wire logic [55:0] out_frac,
   input wire logic irq_req,
   input wire logic [7:0] irq_vector
);
   // ********
   // Properties
   // ********
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_trap_op;
      instr_done && opcode_error && !status_word[14];
   endsequence
   sequence s_ainc;
      spec_valid && spec_mode == 3'h2 && spec_reg != 3'h7 && !status_word[7];
   endsequence

   // Octal 244
   vector_fixed_a: assert property (irq_vector == 8'hA4)
      else $error("interrupt vector wrong");
   opcode_irq_a: assert property (s_trap_op |=> irq_req)
      else $error("opcode error gave no interrupt");
   quiet_idle_a: assert property (!instr_done |=> !irq_req)
      else $error("interrupt without instruction end");
   disable_irq_a: assert property (status_word[14] |=> !irq_req)
      else $error("interrupt while disabled");
   sticky_set_a: assert property (irq_req |-> status_word[15])
      else $error("error flag clear on interrupt");
   sticky_hold_a: assert property (status_word[15] && !status_load |=> status_word[15])
      else $error("error flag dropped");
   store_pulse_a: assert property (store_status_op |=> store_valid)
      else $error("store status not answered");
   store_quiet_a: assert property (!store_status_op |=> !store_valid)
      else $error("store answer without request");
   ainc_step_a: assert property (s_ainc |=> addr_reg_we && addr_reg_value == $past(spec_reg_value) + 16'h0004)
      else $error("single increment step wrong");
   adec_double_a: assert property (spec_valid && spec_mode == 3'h4 && spec_reg != 3'h7 && status_word[7]
      |=> addr_reg_value == $past(spec_reg_value) - 16'h0008)
      else $error("double decrement step wrong");
   acc_range_a: assert property (spec_valid && spec_mode == 3'h0 |=> addr_acc_bad == ($past(spec_acc) > 3'h5))
      else $error("accumulator range wrong");
   imm_words_a: assert property (spec_valid && spec_mode == 3'h2 && spec_reg == 3'h7 |=> addr_words == 3'h1)
      else $error("immediate width wrong");
   zero_exact_a: assert property (opnd_valid && opnd_exp == 8'h00 && !opnd_sign |=> opnd_exact_zero)
      else $error("zero exponent not exact zero");
   under_zero_a: assert property (res_valid && !status_word[10] && $signed(res_exp) < -10'sd1
      |=> out_exp == 8'h00 && out_frac == 56'h0)
      else $error("untrapped underflow not zero");
endmodule

bind fxr_core fxr_core_props u_props (.*);

//--- sim/fxr_core_tb.sv
// Self-checking bench for the float exception, addressing and rounding core
`timescale 1ns/1ps

module fxr_core_tb;
   logic sys_clk = 1'b0, rst_n = 1'b0, status_load = 1'b0, store_status_op = 1'b0, maint_trap_enable = 1'b0;
   logic instr_done = 1'b0, opcode_error = 1'b0, conversion_error = 1'b0, maint_trap = 1'b0, spec_valid = 1'b0;
   logic opnd_valid = 1'b0, opnd_from_mem = 1'b0, opnd_is_divisor = 1'b0, opnd_sign = 1'b0, res_valid = 1'b0;
   logic [15:0] status_load_data = 16'h0000, instr_pc = 16'h0000;
   logic [2:0] spec_mode = 3'h0, spec_reg = 3'h0, spec_acc = 3'h0;
   logic [7:0] opnd_exp = 8'h00;
   logic [9:0] res_exp = 10'h000;
   logic [59:0] res_frac = 60'h0;
   logic [15:0] status_word, store_address, spec_reg_value, addr_ea, addr_reg_value;
   logic store_valid, addr_use_acc, addr_acc_bad, addr_reg_we, opnd_exact_zero, opnd_abort, overflow_flag, irq_req;
   logic addr_valid, addr_deferred, addr_indexed, out_valid, out_sign;
   logic [3:0] store_code;
   logic [2:0] addr_words, addr_acc_sel;
   logic [7:0] out_exp, irq_vector;
   logic [55:0] out_frac;
   logic irq, res_sign = 1'b0;
   logic [3:0] codes [7] = '{4'h2, 4'hC, 4'h4, 4'h6, 4'h8, 4'hA, 4'hE};
   int failures = 0, n_tests = 0;

   fxr_core uut (.*);

   fxr_host_regs u_host (.*);

   always #10 sys_clk = ~sys_clk;

   // ********
   // Access tasks
   // ********
   task automatic check_val(input logic [71:0] got, input logic [71:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic load(input logic [15:0] d);
      @(negedge sys_clk);
      status_load = 1'b1;
      status_load_data = d;
      @(negedge sys_clk);
      status_load = 1'b0;
   endtask

   task automatic store(input logic [3:0] c, input logic [15:0] a);
      @(negedge sys_clk);
      store_status_op = 1'b1;
      @(negedge sys_clk);
      store_status_op = 1'b0;
      check_bit(store_valid, 1'b1);
      check_val({store_code, store_address}, {c, a});
   endtask

   // Cause k: 0 opcode, 1 undefined, 2 divide by zero, 3 conversion, 4 overflow, 5 underflow, 6 maint, 7 none
   task automatic run_instr(input logic [15:0] pc, input int k);
      @(negedge sys_clk);
      instr_done = 1'b1;
      instr_pc = pc;
      opcode_error = (k == 0);
      opnd_valid = (k == 1) || (k == 2);
      opnd_from_mem = (k == 1);
      opnd_sign = (k == 1);
      opnd_is_divisor = (k == 2);
      opnd_exp = 8'h00;
      conversion_error = (k == 3);
      res_valid = (k == 4) || (k == 5);
      res_sign = (k == 4) || (k == 5);
      res_exp = (k == 4) ? 10'h101 : 10'h3FE;
      res_frac = 60'h400000000000000;
      maint_trap = (k == 6);
      @(negedge sys_clk);
      {instr_done, opcode_error, opnd_valid, opnd_from_mem, conversion_error, res_valid, maint_trap} = '0;
      irq = irq_req;
   endtask

   task automatic result(input logic [59:0] f, input logic [9:0] e);
      @(negedge sys_clk);
      res_valid = 1'b1;
      res_frac = f;
      res_exp = e;
      @(negedge sys_clk);
      res_valid = 1'b0;
   endtask

   task automatic spec(input logic [2:0] m, input logic [2:0] r, input logic [2:0] a);
      @(negedge sys_clk);
      spec_valid = 1'b1;
      spec_mode = m;
      spec_reg = r;
      spec_acc = a;
      @(negedge sys_clk);
      spec_valid = 1'b0;
   endtask

   task automatic operand(input logic div, input logic neg, input logic [7:0] e);
      @(negedge sys_clk);
      opnd_valid = 1'b1;
      opnd_is_divisor = div;
      opnd_sign = neg;
      opnd_from_mem = 1'b1;
      opnd_exp = e;
      @(negedge sys_clk);
      opnd_valid = 1'b0;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ********
   // Tests
   // ********
   initial
   begin
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      check_val(status_word, 16'h0000);
      store(4'h0, 16'h0000);
      $display("test reset done");
      load(16'h0F00);
      maint_trap_enable = 1'b1;
      for (int k = 0; k < 7; k++)
      begin
         run_instr(16'h2000 + 16'(2 * k), k);
         check_bit(irq, 1'b1);
         check_bit(status_word[15], 1'b1);
         if (k == 4)
            check_val({out_sign, overflow_flag, out_exp, out_frac}, {2'b11, 8'h01, 56'h80000000000000});
         if (k == 5)
            check_val({out_sign, out_exp, out_frac}, {1'b1, 8'hFE, 56'h80000000000000});
         store(codes[k], 16'h2000 + 16'(2 * k));
      end
      $display("test trapped exceptions done");
      load(16'h0000);
      maint_trap_enable = 1'b0;
      for (int k = 1; k < 7; k++)
      begin
         if (k != 2)
         begin
            run_instr(16'h5000, k);
            check_bit(irq, 1'b0);
            if (k >= 4 && k <= 5)
               check_val({overflow_flag, out_sign, out_exp, out_frac}, {1'(k == 4), 65'h0});
         end
      end
      check_bit(status_word[15], 1'b0);
      store(4'hE, 16'h200C);
      $display("test untrapped exceptions done");
      load(16'h4000);
      run_instr(16'h3000, 0);
      check_bit(irq, 1'b0);
      check_bit(status_word[15], 1'b1);
      store(4'h2, 16'h3000);
      run_instr(16'h4000, 7);
      check_bit(irq, 1'b0);
      store(4'h2, 16'h3000);
      load(16'hFFFF);
      check_val(status_word, 16'hCFFF);
      load(16'h0000);
      check_val(status_word, 16'h0000);
      $display("test disable and status done");
      result({2'b01, 23'h000001, 1'b1, 34'h0}, 10'h081);
      check_val({out_exp, out_frac}, {8'h81, 24'h800002, 32'h0});
      load(16'h0020);
      result({2'b01, 23'h000001, 1'b1, 34'h0}, 10'h081);
      check_val({out_exp, out_frac}, {8'h81, 24'h800001, 32'h0});
      load(16'h0080);
      result({2'b01, 55'h1, 1'b1, 2'b00}, 10'h081);
      check_val({out_exp, out_frac}, {8'h81, 56'h80000000000002});
      result({2'b01, 55'h1, 1'b0, 2'b11}, 10'h081);
      check_val({out_exp, out_frac}, {8'h81, 56'h80000000000001});
      result({1'b0, 57'h1FFFFFFFFFFFFFF, 2'b00}, 10'h081);
      check_val({out_valid, out_exp, out_frac}, {1'b1, 8'h82, 56'h80000000000000});
      result({1'b1, 59'h0}, 10'h081);
      check_val({out_exp, out_frac}, {8'h82, 56'h80000000000000});
      $display("test rounding done");
      spec(3'h4, 3'h2, 3'h0);
      check_val({addr_reg_we, addr_words, addr_ea, addr_reg_value}, {1'b1, 3'h4, 16'h11F8, 16'h11F8});
      spec(3'h2, 3'h2, 3'h0);
      check_val({addr_reg_we, addr_words, addr_ea, addr_reg_value}, {1'b1, 3'h4, 16'h11F8, 16'h1200});
      load(16'h0000);
      spec(3'h2, 3'h1, 3'h0);
      check_val({addr_reg_we, addr_words, addr_ea, addr_reg_value}, {1'b1, 3'h2, 16'h1100, 16'h1104});
      spec(3'h2, 3'h7, 3'h0);
      check_val({addr_reg_we, addr_words, addr_ea, addr_reg_value}, {1'b1, 3'h1, 16'h1700, 16'h1702});
      spec(3'h0, 3'h0, 3'h5);
      check_val({addr_use_acc, addr_acc_bad, addr_reg_we, addr_words}, {1'b1, 1'b0, 1'b0, 3'h0});
      spec(3'h0, 3'h0, 3'h6);
      check_bit(addr_acc_bad, 1'b1);
      spec(3'h1, 3'h3, 3'h4);
      check_val({addr_use_acc, addr_acc_bad, addr_reg_we, addr_deferred, addr_ea}, {3'b010, 1'b1, 16'h1300});
      for (int m = 0; m < 8; m++)
      begin
         spec(3'(m), 3'h4, 3'h1);
         check_val({addr_valid, addr_use_acc, addr_deferred, addr_indexed, addr_acc_sel},
            {1'b1, 1'(m == 0), 1'(m % 2), 1'(m >= 6), 3'h1});
      end
      $display("test addressing done");
      load(16'h0800);
      operand(1'b0, 1'b0, 8'h00);
      check_val({opnd_exact_zero, opnd_abort}, 2'b10);
      operand(1'b1, 1'b0, 8'h00);
      check_bit(opnd_abort, 1'b1);
      operand(1'b0, 1'b1, 8'h00);
      check_val({opnd_exact_zero, opnd_abort}, 2'b01);
      operand(1'b0, 1'b0, 8'h81);
      check_val({opnd_exact_zero, opnd_abort}, 2'b00);
      load(16'h0000);
      operand(1'b0, 1'b1, 8'h00);
      check_val({opnd_exact_zero, opnd_abort}, 2'b10);
      $display("test operand zero done");
      summarize();
   end

   initial
   begin
      repeat (4000) @(posedge sys_clk);
      failures++;
      $display("watchdog expired");
      summarize();
   end
endmodule
